/* core/rx_overhead_consts.svh */
// Purpose: constants for the receive overhead serial ports
// Assumes: 40 MHz system clock; port clock derived by division
// Notes:   STS-3 transport overhead is 9 rows x 9 columns of bytes
`ifndef RX_OVERHEAD_CONSTS_SVH
`define RX_OVERHEAD_CONSTS_SVH

`define OH_HALF_DIV        4'h9
`define OH_ROWS            4'h9
`define OH_COLS            4'h9
`define OH_BITS_LAST       3'h7
`define OH_A1_ROW          4'h0
`define OH_A1_COL          4'h0
`define OH_FIRST_BIT       3'h0
`define OH_E1_ROW          4'h3
`define OH_E1_COL          4'h6
`define OH_F1_ROW          4'h1
`define OH_F1_COL          4'h6
`define OH_E2_ROW          4'h8
`define OH_E2_COL          4'h6
`define OH_DCC_ROW_FIRST   4'h5
`define OH_DCC_ROW_LAST    4'h7
`define OH_DCC_COL_0       4'h0
`define OH_DCC_COL_1       4'h3
`define OH_DCC_COL_2       4'h6

`endif

/* core/rx_overhead_pkg.sv */
// Purpose: shared types for the receive overhead serial ports
// Assumes: nothing beyond the constants header
// Notes:   byte position within the overhead block travels as a struct
package rx_overhead_pkg;

  typedef struct packed {
    logic [3:0] row;
    logic [3:0] col;
    logic [2:0] bit_idx;
  } oh_pos_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic mark;
  } serial_lane_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_SHIFT = 2'b11
  } oh_state_t;

endpackage : rx_overhead_pkg

/* core/rx_overhead_lane.sv */
// Purpose: one serial output lane updated on the port clock falling edge
// Assumes: fall_i is a one-cycle pulse in sys_clk_i
// Notes:   outputs are straight flip-flops
`timescale 1ns/1ps
module rx_overhead_lane (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         fall_i,
  input  wire rx_overhead_pkg::serial_lane_t lane_i,
  output      rx_overhead_pkg::serial_lane_t lane_o
);
  import rx_overhead_pkg::*;

  serial_lane_t lane_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lane_r <= '0;
    end else if (fall_i) begin
      lane_r <= lane_i;
    end
  end

  assign lane_o = lane_r;
endmodule : rx_overhead_lane

/* core/rx_overhead_serial_ports.sv */
// Purpose: serial transport overhead, line channel and order-wire output ports
// Assumes: overhead bytes arrive as a byte stream with a frame start marker
// Notes:   port clock is a divided copy of sys_clk_i and runs free
//
// Summary of operation
// R01: free-running port clock, data changes on falling
// R02: far end samples data on rising edge
// R03: overhead valid high for every real bit
// R04: all overhead bytes shifted out serially
// R05: frame indicator high eight clocks during A1
// R06: one-clock pre-pulse variant not taken; see note
// R07: line channel valid high per line bit
// R08: line channel outputs change on falling edge
// R09: line channel carries bytes D4 through D12
// R10: far controller samples line valid each rising
// R11: far controller latches data when valid high
// R12: order-wire pulse one clock on E1 bit0
// R13: E1, F1, E2 shifted with order-wire valid
// R14: order-wire outputs change on falling edge
// R15: far logic latches from pulse until valid low
// R16: data undefined while its valid is low
`timescale 1ns/1ps
`include "rx_overhead_consts.svh"
module rx_overhead_serial_ports (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] oh_byte_i,
  input  wire logic       oh_byte_valid_i,
  input  wire logic       oh_frame_start_i,
  output      logic       oh_byte_ready_o,
  output      logic       rx_overhead_port_clock_o,
  output      logic       rx_overhead_bit_valid_o,
  output      logic       rx_overhead_serial_data_o,
  output      logic       rx_overhead_frame_indicator_o,
  output      logic       rx_line_channel_valid_o,
  output      logic       rx_line_channel_data_o,
  output      logic       rx_orderwire_frame_pulse_o,
  output      logic       rx_orderwire_data_o,
  output      logic       rx_orderwire_valid_o
);
  import rx_overhead_pkg::*;

  // ---------------------------------------------------------------
  // port clock divider
  // ---------------------------------------------------------------
  // ten cycles each phase; outputs move with the fall, so the far
  // end's rise lands mid-bit
  logic [3:0] div_r;
  logic       pclk_r;
  wire        div_end  = (div_r == `OH_HALF_DIV);
  wire        fall_now = div_end && pclk_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r  <= 4'h0;
      pclk_r <= 1'b0;
    end else begin
      div_r  <= div_end ? 4'h0 : div_r + 4'h1;
      pclk_r <= div_end ? ~pclk_r : pclk_r; // see R01
    end
  end

  // ---------------------------------------------------------------
  // byte holding and bit sequencer
  // ---------------------------------------------------------------
  oh_state_t  state_r;
  oh_pos_t    pos_r;
  oh_pos_t    pos_nxt;
  logic [7:0] shift_r;
  logic       ready_r;
  logic [7:0] hold_r;
  logic       hold_ok_r;

  wire take_byte = oh_byte_valid_i && ready_r;
  wire last_bit  = (pos_r.bit_idx == `OH_BITS_LAST);
  wire last_col  = (pos_r.col == `OH_COLS - 4'h1);
  wire last_row  = (pos_r.row == `OH_ROWS - 4'h1);
  // the byte about to load is the final one of the block
  wire next_last = last_row && (pos_r.col == `OH_COLS - 4'h2);
  // byte must be waiting when the current byte runs out
  wire need_byte = (state_r == ST_SHIFT) ? (fall_now && last_bit) : 1'b0;

  // ---------------------------------------------------------------
  // next position in the overhead block, row-major
  // ---------------------------------------------------------------
  assign pos_nxt.bit_idx = pos_r.bit_idx + 3'h1;
  assign pos_nxt.col     = !last_bit ? pos_r.col :
                           last_col  ? 4'h0 : pos_r.col + 4'h1;
  assign pos_nxt.row     = (last_bit && last_col) ? pos_r.row + 4'h1 : pos_r.row;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      pos_r   <= '0;
      shift_r <= 8'h00;
      ready_r <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take_byte && oh_frame_start_i) begin
            shift_r <= oh_byte_i;
            ready_r <= 1'b0;
            pos_r   <= '0;
            state_r <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          // lead-in lasting up to one port period, to the next fall, so the first bit stands a full period
          if (fall_now) begin
            state_r <= ST_SHIFT;
            ready_r <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (take_byte) begin
            ready_r <= 1'b0;
          end
          if (fall_now) begin
            pos_r   <= pos_nxt;
            shift_r <= {shift_r[6:0], 1'b0}; // see R04
            if (last_bit) begin
              shift_r <= hold_r;
              // no request past the block end: a following start byte
              // would land in the hold buffer and be lost
              ready_r <= !next_last;
              if (last_col && last_row) begin
                state_r <= ST_IDLE;
                ready_r <= 1'b1;
              end else if (!hold_ok_r) begin
                // source underran; drop the frame rather than emit junk
                state_r <= ST_IDLE;
                ready_r <= 1'b1;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // next byte buffer, loaded while the current byte shifts; emptied
  // outside a frame so a stale byte never feeds the next one
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_r    <= 8'h00;
      hold_ok_r <= 1'b0;
    end else if (state_r != ST_SHIFT) begin
      hold_ok_r <= 1'b0;
    end else if (take_byte) begin
      hold_r    <= oh_byte_i;
      hold_ok_r <= 1'b1;
    end else if (need_byte) begin
      hold_ok_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // byte classification for the next falling edge
  // ---------------------------------------------------------------
  wire shifting = (state_r == ST_SHIFT);
  wire cur_bit  = shift_r[7];
  wire is_a1    = shifting && pos_r.row == `OH_A1_ROW && pos_r.col == `OH_A1_COL;
  wire col_dcc  = pos_r.col == `OH_DCC_COL_0 || pos_r.col == `OH_DCC_COL_1 ||
                  pos_r.col == `OH_DCC_COL_2;
  wire is_dcc   = shifting && pos_r.row >= `OH_DCC_ROW_FIRST &&
                  pos_r.row <= `OH_DCC_ROW_LAST && col_dcc; // see R09
  wire is_e1    = pos_r.row == `OH_E1_ROW && pos_r.col == `OH_E1_COL;
  wire is_f1    = pos_r.row == `OH_F1_ROW && pos_r.col == `OH_F1_COL;
  wire is_e2    = pos_r.row == `OH_E2_ROW && pos_r.col == `OH_E2_COL;
  wire is_ow    = shifting && (is_e1 || is_f1 || is_e2);

  serial_lane_t toh_nxt;
  serial_lane_t dcc_nxt;
  serial_lane_t ow_nxt;
  serial_lane_t toh_q;
  serial_lane_t dcc_q;
  serial_lane_t ow_q;

  // frame mark spans the whole A1 byte, not a pre-pulse; see R06
  assign toh_nxt = '{valid: shifting, data: cur_bit, mark: is_a1};   // see R03, R05
  // data lanes carry the shift bit even while their valid is low;
  // cheaper than gating, and the far end ignores it there
  assign dcc_nxt = '{valid: is_dcc, data: cur_bit, mark: 1'b0};      // see R07, R16
  assign ow_nxt  = '{valid: is_ow, data: cur_bit,
                     mark: is_ow && is_e1 && pos_r.bit_idx == `OH_FIRST_BIT}; // see R12, R13

  // ---------------------------------------------------------------
  // output lanes, all updated on the port clock falling edge
  // ---------------------------------------------------------------
  rx_overhead_lane u_toh_lane (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .fall_i    (fall_now), // see R01
    .lane_i    (toh_nxt),
    .lane_o    (toh_q)
  );

  rx_overhead_lane u_dcc_lane (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .fall_i    (fall_now), // see R08
    .lane_i    (dcc_nxt),
    .lane_o    (dcc_q)
  );

  rx_overhead_lane u_ow_lane (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .fall_i    (fall_now), // see R14
    .lane_i    (ow_nxt),
    .lane_o    (ow_q)
  );

  assign oh_byte_ready_o               = ready_r;
  assign rx_overhead_port_clock_o      = pclk_r;
  assign rx_overhead_bit_valid_o       = toh_q.valid;
  assign rx_overhead_serial_data_o     = toh_q.data;
  assign rx_overhead_frame_indicator_o = toh_q.mark;
  assign rx_line_channel_valid_o       = dcc_q.valid;
  assign rx_line_channel_data_o        = dcc_q.data;
  assign rx_orderwire_frame_pulse_o    = ow_q.mark;
  assign rx_orderwire_data_o           = ow_q.data;
  assign rx_orderwire_valid_o          = ow_q.valid;
endmodule : rx_overhead_serial_ports

/* verification/rx_overhead_serial_ports_assertions.sv */
// Purpose: port timing checks
// Assumes: port clock 10 high, 10 low
// Notes:   bound to every instance
`timescale 1ns/1ps
module rx_overhead_serial_ports_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rx_overhead_port_clock_o,
  input wire logic rx_overhead_bit_valid_o,
  input wire logic rx_overhead_frame_indicator_o,
  input wire logic rx_line_channel_valid_o,
  input wire logic rx_orderwire_frame_pulse_o,
  input wire logic rx_orderwire_valid_o,
  input wire logic rx_overhead_serial_data_o,
  input wire logic rx_line_channel_data_o,
  input wire logic rx_orderwire_data_o
);
  wire pc = rx_overhead_port_clock_o;
  wire tv = rx_overhead_bit_valid_o;
  wire fi = rx_overhead_frame_indicator_o;
  wire lv = rx_line_channel_valid_o;
  wire op = rx_orderwire_frame_pulse_o;
  wire ov = rx_orderwire_valid_o;
  wire [2:0] dq = {rx_overhead_serial_data_o, rx_line_channel_data_o, rx_orderwire_data_o};
  // mark lasts 160 cycles, too long for a repetition
  logic [7:0] fi_cnt_r;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i) fi_cnt_r <= 8'h00;
    else fi_cnt_r <= fi ? fi_cnt_r + 8'h01 : 8'h00;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hi; ##9 pc ##1 !pc; endsequence
  sequence s_lo; ##9 !pc ##1 pc; endsequence
  a_clk_high: assert property ($rose(pc) |-> s_hi) else $error("clock high");
  a_clk_low: assert property ($fell(pc) |-> s_lo) else $error("clock low");
  a_out_low: assert property ($changed({tv, fi, lv, op, ov, dq}) |-> !pc) else $error("moved");
  a_fi_eight: assert property ($fell(fi) |-> fi_cnt_r == 8'ha0) else $error("mark length");
  a_fi_valid: assert property (fi |-> tv) else $error("mark alone");
  a_ow_one: assert property ($rose(op) |-> ##19 op ##1 !op) else $error("pulse length");
  a_ow_qual: assert property (op |-> ov && !lv) else $error("pulse alone");
  a_lc_toh: assert property (lv |-> tv && !ov) else $error("line bit");
endmodule : rx_overhead_serial_ports_assertions
bind rx_overhead_serial_ports rx_overhead_serial_ports_assertions chk (.*);

/* verification/oh_far_end.sv */
// Purpose: far-end sampler of the ports
// Assumes: outputs settle before a rise
// Notes:   bench reads the queue
`timescale 1ns/1ps
module oh_far_end (
  input wire logic pclk_i,
  input wire logic tv_i,
  input wire logic td_i,
  input wire logic fi_i,
  input wire logic lv_i,
  input wire logic ld_i,
  input wire logic ov_i,
  input wire logic op_i,
  input wire logic od_i
);
  logic [6:0] tq[$];
  // data under a low qualifier is masked, it means nothing
  always @(posedge pclk_i)
    if (tv_i) tq.push_back({fi_i, lv_i, lv_i & ld_i, ov_i, op_i, ov_i & od_i, td_i});
endmodule : oh_far_end

/* verification/tb_top.sv */
// Purpose: bench for the overhead ports
// Assumes: far end samples on port rise
// Notes:   random, corner, abort frames
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, v = 1'b0, fs = 1'b0;
  logic [7:0] b = 8'h00, fr[81];
  logic [31:0] rs = 32'h13;
  logic [6:0] eb[$];
  int err_count = 0, n_checks = 0;
  wire rdy, pc, tv, td, fi, lv, ld, op, od, ov;
  rx_overhead_serial_ports dut (.sys_clk_i(clk), .rst_i(rst), .oh_byte_i(b), .oh_byte_valid_i(v),
    .oh_frame_start_i(fs), .oh_byte_ready_o(rdy), .rx_overhead_port_clock_o(pc),
    .rx_overhead_bit_valid_o(tv), .rx_overhead_serial_data_o(td), .rx_overhead_frame_indicator_o(fi),
    .rx_line_channel_valid_o(lv), .rx_line_channel_data_o(ld), .rx_orderwire_frame_pulse_o(op),
    .rx_orderwire_data_o(od), .rx_orderwire_valid_o(ov));
  oh_far_end far (.pclk_i(pc), .tv_i(tv), .td_i(td), .fi_i(fi), .lv_i(lv), .ld_i(ld),
    .ov_i(ov), .op_i(op), .od_i(od));
  always #12.5 clk = ~clk;
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic send(int n, bit st);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      b <= fr[i];
      fs <= st && i == 0;
      v <= 1'b1;
      // ready read at the falling edge, clear of its update
      @(negedge clk);
      while (rdy !== 1'b1) @(negedge clk);
    end
    @(posedge clk);
    v <= 1'b0;
  endtask : send
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xorshift
  // far-end view of one bit: row-major byte i, bit j, MSB first
  function automatic logic [6:0] expect_bit(int i, int j, logic d);
    logic l, o;
    l = i / 9 inside {[5:7]} && i % 9 inside {0, 3, 6};
    o = i % 9 == 6 && i / 9 inside {1, 3, 8};
    return {i == 0, l, l & d, o, i == 33 && j == 7, o & d, d};
  endfunction : expect_bit
  task automatic frame(int n, bit c);
    for (int i = 0; i < n; i++) begin
      rs = xorshift(rs);
      fr[i] = c ? {8{i[0]}} : rs[7:0];
      for (int j = 7; j >= 0; j--)
        eb.push_back(expect_bit(i, j, fr[i][j]));
    end
    send(n, 1'b1);
  endtask : frame
  task automatic drain(string nm);
    while (tv !== 1'b0) @(negedge clk);
    check(nm, 32'(far.tq.size()), 32'(eb.size()));
    foreach (eb[i]) check(nm, 32'(far.tq[i]), 32'(eb[i]));
    $display("test %s done", nm);
  endtask : drain
  task automatic complete_run();
    $display("checks %0d bad %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("idle after reset", 32'({rdy, tv, lv, ov}), 32'h8);
    fr[0] = 8'h3c;
    send(1, 1'b0);
    frame(81, 1'b1);
    frame(81, 1'b0);
    drain("two frames");
    frame(10, 1'b0);
    drain("abort");
    frame(81, 1'b0);
    drain("recovery");
    complete_run();
  end
  initial begin
    #1500000;
    err_count++;
    complete_run();
  end
endmodule : tb_top
